// [design/adc_clock_and_powerdown_control.sv]
`timescale 1ns/100ps
`default_nettype none

module adc_clock_and_powerdown_control (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              resetn,
  // axi4-lite write address and data
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  // axi4-lite write response
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  // axi4-lite read
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  // converter side
  input  wire logic                              extClkIn,
  input  wire logic [11:0]                       analogCode,
  input  wire logic                              shutdown_pin_n,
  output logic [2:0]                             channelSel,
  output logic                                   rangeSel,
  output logic                                   refBufferEnable,
  output logic                                   bandgapEnable,
  // host signalling
  output logic                                   conversionDoneFlagN,
  output logic                                   irq
);

  import adc_ctrl_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic             awHave_q, awHave_d, wHave_q, wHave_d;
  logic [7:0]       awAddr_q, awAddr_d;
  logic [31:0]      wData_q, wData_d;
  logic             wLane0_q, wLane0_d;
  logic             awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]       bresp_d, rresp_d;
  logic [31:0]      rdata_d;
  logic             doWrite, ctrlWrite, irqClearWrite, irqEnableWrite, resultRead;

  adc_state_t       state_q, state_d;
  logic [7:0]       ctrl_q, ctrl_d;
  logic [1:0]       pdPending_q, pdPending_d;
  logic             clkInternal_q, clkInternal_d;
  logic             hwDown_q, hwDown_d;
  logic [CNT_W-1:0] tickCnt_q, tickCnt_d;
  logic [11:0]      sample_q, sample_d;
  logic [11:0]      result_q, result_d;
  logic             resultBip_q, resultBip_d;
  logic             doneN_d, refBuf_d, irq_d;
  logic [IRQ_W-1:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d, events;
  logic             convTick, convRun;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic regMapped(input logic [7:0] a);
    regMapped = (a == CTRL_OFS) || (a == RESULT_OFS) || (a == STATUS_OFS) ||
                (a == IRQ_STATUS_OFS) || (a == IRQ_CLEAR_OFS) || (a == IRQ_ENABLE_OFS);
  endfunction

  function automatic logic [11:0] formatCode(input logic [11:0] c, input logic polarity_select);
    formatCode = polarity_select ? {~c[11], c[10:0]} : c;
  endfunction

  // high nibble repeats the sign when bipolar, zero otherwise
  function automatic logic [15:0] extendCode(input logic [11:0] c, input logic polarity_select);
    extendCode = {{4{polarity_select & c[11]}}, c};
  endfunction

  function automatic logic busyState(input adc_state_t s);
    busyState = (s == S_ACQ_INT) || (s == S_ACQ_EXT) || (s == S_CONVERT);
  endfunction

  // ****************************************
  // bus slave next state
  // ****************************************
  always_comb begin
    awHave_d  = awHave_q;
    awAddr_d  = awAddr_q;
    wHave_d   = wHave_q;
    wData_d   = wData_q;
    wLane0_d  = wLane0_q;
    bvalid_d  = bvalid;
    bresp_d   = bresp;
    rvalid_d  = rvalid;
    rdata_d   = rdata;
    rresp_d   = rresp;
    if (awvalid && awready) begin
      awHave_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHave_d  = 1'b1;
      wData_d  = wdata;
      wLane0_d = wstrb[0];
    end
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    // bus serves accesses in every power state
    doWrite = awHave_q && wHave_q && !bvalid;
    if (doWrite) begin
      awHave_d = 1'b0;
      wHave_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = regMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    // every writable register fits in one byte, so lane 0 carries every write
    ctrlWrite      = doWrite && wLane0_q && (awAddr_q == CTRL_OFS);
    irqClearWrite  = doWrite && wLane0_q && (awAddr_q == IRQ_CLEAR_OFS);
    irqEnableWrite = doWrite && wLane0_q && (awAddr_q == IRQ_ENABLE_OFS);
    awready_d = !awHave_d;
    wready_d  = !wHave_d;

    if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    resultRead = 1'b0;
    if (arvalid && arready) begin
      rvalid_d   = 1'b1;
      rresp_d    = regMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      resultRead = (araddr == RESULT_OFS);
      case (araddr)
        CTRL_OFS:       rdata_d = {24'h000000, ctrl_q};
        RESULT_OFS:     rdata_d = {16'h0000, extendCode(result_q, resultBip_q)};
        STATUS_OFS: begin
          rdata_d              = 32'h00000000;
          rdata_d[ST_BUSY]     = busyState(state_q);
          rdata_d[ST_CLK_INT]  = clkInternal_q;
          rdata_d[ST_STANDBY]  = (state_q == S_STANDBY_PD);
          rdata_d[ST_DEEP]     = (state_q == S_DEEP_PD);
          rdata_d[ST_DONE_N]   = conversionDoneFlagN;
          rdata_d[ST_HW_SHUTDOWN_PIN_N]  = hwDown_q;
        end
        IRQ_STATUS_OFS: rdata_d = {29'h00000000, irqStat_q};
        IRQ_ENABLE_OFS: rdata_d = {29'h00000000, irqEn_q};
        default:        rdata_d = 32'h00000000;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      awHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHave_q  <= 1'b0;
      wData_q  <= 32'h00000000;
      wLane0_q <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      arready  <= 1'b0;
      rvalid   <= 1'b0;
      rdata    <= 32'h00000000;
      rresp    <= RESP_OKAY;
    end else begin
      awHave_q <= awHave_d;
      awAddr_q <= awAddr_d;
      wHave_q  <= wHave_d;
      wData_q  <= wData_d;
      wLane0_q <= wLane0_d;
      awready  <= awready_d;
      wready   <= wready_d;
      bvalid   <= bvalid_d;
      bresp    <= bresp_d;
      arready  <= arready_d;
      rvalid   <= rvalid_d;
      rdata    <= rdata_d;
      rresp    <= rresp_d;
    end
  end

  // ****************************************
  // conversion clock
  // ****************************************
  // external clock edges are counted as they come; range is the host's duty
  assign convRun = (state_q == S_ACQ_INT) || (state_q == S_CONVERT);

  conv_clock_gen convClock (
    .clk          (clk),
    .resetn       (resetn),
    .internalMode (clkInternal_q),
    .run          (convRun),
    .extClkIn     (extClkIn),
    .tick         (convTick)
  );

  // ****************************************
  // converter sequence and power
  // ****************************************
  always_comb begin
    state_d       = state_q;
    ctrl_d        = ctrl_q;
    pdPending_d   = pdPending_q;
    clkInternal_d = clkInternal_q;
    hwDown_d      = hwDown_q;
    tickCnt_d     = tickCnt_q;
    sample_d      = sample_q;
    result_d      = result_q;
    resultBip_d   = resultBip_q;
    doneN_d       = conversionDoneFlagN;
    events        = '0;
    // read clears first so a completing conversion wins below
    if (resultRead) begin
      doneN_d = 1'b1;
    end
    if (ctrlWrite) begin
      ctrl_d      = wData_q[7:0];
      pdPending_d = wData_q[CB_PM_LSB +: 2];
      doneN_d     = 1'b1;
      // only normal codes move the clock mode
      if (!wData_q[CB_PM_LSB + 1]) begin
        clkInternal_d = wData_q[CB_PM_LSB];
      end
    end

    if (!shutdown_pin_n) begin
      if (busyState(state_q)) begin
        events[IRQ_ABORT] = 1'b1;
      end
      if (state_q != S_DEEP_PD) begin
        events[IRQ_PDOWN] = 1'b1;
      end
      state_d   = S_DEEP_PD;
      hwDown_d  = 1'b1;
      tickCnt_d = '0;
    end else if (hwDown_q) begin
      state_d  = S_IDLE;
      hwDown_d = 1'b0;
    end else if (ctrlWrite) begin
      // a control write wakes unless the shutdown pin holds or has just released deep power-down; a write mid-conversion restarts acquisition
      tickCnt_d = '0;
      if (wData_q[CB_ACQ_EXT]) begin
        state_d = S_ACQ_EXT;
      end else if (state_q == S_ACQ_EXT) begin
        state_d  = S_CONVERT;
        sample_d = analogCode;
      end else begin
        state_d = S_ACQ_INT;
      end
    end else begin
      case (state_q)
        S_ACQ_INT: begin
          if (convTick) begin
            if (tickCnt_q == CNT_W'(ACQ_CYCLES - 1)) begin
              state_d   = S_CONVERT;
              sample_d  = analogCode;
              tickCnt_d = '0;
            end else begin
              tickCnt_d = tickCnt_q + CNT_W'(1);
            end
          end
        end
        S_CONVERT: begin
          if (convTick) begin
            if (tickCnt_q == CNT_W'(CONV_CYCLES - 1)) begin
              tickCnt_d          = '0;
              result_d           = formatCode(sample_q, ctrl_q[CB_POLARITY]);
              resultBip_d        = ctrl_q[CB_POLARITY];
              doneN_d            = 1'b0;
              events[IRQ_DONE]   = 1'b1;
              if (pdPending_q == PM_STANDBY) begin
                state_d           = S_STANDBY_PD;
                events[IRQ_PDOWN] = 1'b1;
              end else if (pdPending_q == PM_DEEP) begin
                state_d           = S_DEEP_PD;
                events[IRQ_PDOWN] = 1'b1;
              end else begin
                state_d = S_IDLE;
              end
            end else begin
              tickCnt_d = tickCnt_q + CNT_W'(1);
            end
          end
        end
        default: begin
        end
      endcase
    end

    // reference buffer off only in deep power-down
    refBuf_d = (state_d != S_DEEP_PD);

    // set wins over a clear in the same cycle
    irqStat_d = irqStat_q;
    if (irqClearWrite) begin
      irqStat_d = irqStat_d & ~wData_q[IRQ_W-1:0];
    end
    irqStat_d = irqStat_d | events;
    irqEn_d   = irqEnableWrite ? wData_q[IRQ_W-1:0] : irqEn_q;
    irq_d     = |(irqStat_d & irqEn_d);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      // normal mode, external clock, flag high
      state_q             <= S_IDLE;
      ctrl_q              <= CTRL_RESET;
      pdPending_q         <= PM_NORMAL_EXT;
      clkInternal_q       <= 1'b0;
      hwDown_q            <= 1'b0;
      tickCnt_q           <= '0;
      sample_q            <= 12'h000;
      result_q            <= 12'h000;
      resultBip_q         <= 1'b0;
      conversionDoneFlagN <= 1'b1;
      refBufferEnable     <= 1'b1;
      bandgapEnable       <= 1'b1;
      channelSel          <= 3'h0;
      rangeSel            <= 1'b0;
      irqStat_q           <= IRQ_EN_RESET;
      irqEn_q             <= IRQ_EN_RESET;
      irq                 <= 1'b0;
    end else begin
      state_q             <= state_d;
      ctrl_q              <= ctrl_d;
      pdPending_q         <= pdPending_d;
      clkInternal_q       <= clkInternal_d;
      hwDown_q            <= hwDown_d;
      tickCnt_q           <= tickCnt_d;
      sample_q            <= sample_d;
      result_q            <= result_d;
      resultBip_q         <= resultBip_d;
      conversionDoneFlagN <= doneN_d;
      refBufferEnable     <= refBuf_d;
      // bandgap stays on in every state
      bandgapEnable       <= 1'b1;
      channelSel          <= ctrl_d[CB_CHAN_LSB +: 3];
      rangeSel            <= ctrl_d[CB_RANGE];
      irqStat_q           <= irqStat_d;
      irqEn_q             <= irqEn_d;
      irq                 <= irq_d;
    end
  end

endmodule

`default_nettype wire

// [design/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  RESULT_OFS     = 8'h04;
  localparam logic [7:0]  STATUS_OFS     = 8'h08;
  localparam logic [7:0]  IRQ_STATUS_OFS = 8'h0c;
  localparam logic [7:0]  IRQ_CLEAR_OFS  = 8'h10;
  localparam logic [7:0]  IRQ_ENABLE_OFS = 8'h14;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ****************************************
  // control byte layout
  // ****************************************
  localparam int unsigned CB_PM_LSB      = 6;
  localparam int unsigned CB_ACQ_EXT     = 5;
  localparam int unsigned CB_RANGE       = 4;
  localparam int unsigned CB_POLARITY    = 3;
  localparam int unsigned CB_CHAN_LSB    = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  localparam logic [1:0]  PM_NORMAL_EXT  = 2'h0;
  localparam logic [1:0]  PM_NORMAL_INT  = 2'h1;
  localparam logic [1:0]  PM_STANDBY     = 2'h2;
  localparam logic [1:0]  PM_DEEP        = 2'h3;

  // ****************************************
  // status and interrupt layout
  // ****************************************
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_CLK_INT     = 1;
  localparam int unsigned ST_STANDBY     = 2;
  localparam int unsigned ST_DEEP        = 3;
  localparam int unsigned ST_DONE_N      = 4;
  localparam int unsigned ST_HW_SHUTDOWN_PIN_N     = 5;

  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_DONE       = 0;
  localparam int unsigned IRQ_ABORT      = 1;
  localparam int unsigned IRQ_PDOWN      = 2;
  localparam logic [2:0]  IRQ_EN_RESET   = 3'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned ACQ_CYCLES     = 6;
  localparam int unsigned CONV_CYCLES    = 12;
  localparam int unsigned CNT_W          = 4;
  localparam int unsigned CLK_FREQ_KHZ   = 20000;
  localparam int unsigned INT_OSC_KHZ    = 1560;
  // rounded up so the internal conversion clock never runs above nominal
  localparam int unsigned INT_OSC_DIV    = (CLK_FREQ_KHZ + INT_OSC_KHZ - 1) / INT_OSC_KHZ;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ACQ_INT,
    S_ACQ_EXT,
    S_CONVERT,
    S_STANDBY_PD,
    S_DEEP_PD
  } adc_state_t;

endpackage

// [design/conv_clock_gen.sv]
`timescale 1ns/100ps
`default_nettype none

module conv_clock_gen
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // control
  input  wire logic internalMode,
  input  wire logic run,
  // external conversion clock
  input  wire logic extClkIn,
  // one pulse per conversion clock period
  output logic      tick
);

  logic [CNT_W-1:0] divCnt_q;
  logic [CNT_W-1:0] divCnt_d;
  logic             extPrev_q;
  logic             extPrev_d;
  logic             tick_d;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    extPrev_d = extClkIn;
    divCnt_d  = divCnt_q;
    tick_d    = 1'b0;
    // oscillator idles in external mode and outside internal acquisition and conversion so it never loads anything
    if (!run || !internalMode) begin
      divCnt_d = '0;
    end else if (divCnt_q == CNT_W'(INT_OSC_DIV - 1)) begin
      divCnt_d = '0;
    end else begin
      divCnt_d = divCnt_q + CNT_W'(1);
    end
    if (run) begin
      if (internalMode) begin
        tick_d = (divCnt_q == CNT_W'(INT_OSC_DIV - 1));
      end else begin
        tick_d = extClkIn && !extPrev_q;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      divCnt_q  <= '0;
      extPrev_q <= 1'b0;
      tick      <= 1'b0;
    end else begin
      divCnt_q  <= divCnt_d;
      extPrev_q <= extPrev_d;
      tick      <= tick_d;
    end
  end

endmodule

`default_nettype wire

// [verif/adc_ctrl_checker.sv]
`timescale 1ns/100ps
`default_nettype none

module adc_ctrl_checker
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // register bus
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic              rvalid,
  // converter and host signalling
  input wire logic              shutdown_pin_n,
  input wire logic              refBufferEnable,
  input wire logic              bandgapEnable,
  input wire logic              conversionDoneFlagN
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ****************************************
  // sequences
  // ****************************************
  sequence s_pinLow;
    !shutdown_pin_n ##1 !shutdown_pin_n;
  endsequence
  sequence s_rdTake;
    arvalid && arready;
  endsequence

  // ****************************************
  // properties
  // ****************************************
  property p_rstState;
    $rose(resetn) |-> conversionDoneFlagN && refBufferEnable && !bvalid && !rvalid;
  endproperty
  a_rstState: assert property (p_rstState) else $error("bad state after reset");
  property p_shdnRef;
    s_pinLow |=> !refBufferEnable;
  endproperty
  a_shdnRef: assert property (p_shdnRef) else $error("buffer on in shutdown");
  property p_shdnNoDone;
    s_pinLow |-> !$fell(conversionDoneFlagN);
  endproperty
  a_shdnNoDone: assert property (p_shdnNoDone) else $error("result after abort");
  property p_bandgap;
    1'b1 |-> bandgapEnable;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap off");
  property p_readClr;
    s_rdTake ##0 (araddr == RESULT_OFS) |=> conversionDoneFlagN;
  endproperty
  a_readClr: assert property (p_readClr) else $error("flag kept after read");
  property p_rAns;
    s_rdTake |=> rvalid && !arready;
  endproperty
  a_rAns: assert property (p_rAns) else $error("read not answered");
  property p_rBlock;
    rvalid |-> !arready;
  endproperty
  a_rBlock: assert property (p_rBlock) else $error("read accepted while busy");
  property p_bOnce;
    bvalid && bready |=> !bvalid;
  endproperty
  a_bOnce: assert property (p_bOnce) else $error("write answered twice");
  property p_awTake;
    awvalid && awready |=> !awready;
  endproperty
  a_awTake: assert property (p_awTake) else $error("address taken twice");
endmodule

bind adc_clock_and_powerdown_control adc_ctrl_checker i_chk (
  .clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .shutdown_pin_n(shutdown_pin_n),
  .refBufferEnable(refBufferEnable), .bandgapEnable(bandgapEnable),
  .conversionDoneFlagN(conversionDoneFlagN)
);
`default_nettype wire

// [verif/conv_source.sv]
`timescale 1ns/100ps
`default_nettype none

module conv_source #(
  parameter int          HALF_NS = 500,
  parameter logic [11:0] CODE    = 12'h35c
) (
  // control
  input  wire logic        run,
  // converter side
  output logic             extClk,
  output logic [11:0]      code
);
  // in-band clock
  // 1 MHz at even duty; stands still low outside reset release
  initial begin
    extClk = 1'b0;
    forever begin
      #HALF_NS extClk = run ? ~extClk : 1'b0;
    end
  end
  assign code = CODE;
endmodule
`default_nettype wire

// [verif/adc_clock_and_powerdown_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module adc_clock_and_powerdown_control_tb;
  import adc_ctrl_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  localparam logic [11:0] CODE = 12'h35c;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        shdnN = 1'b1;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, extClk;
  logic        rangeSel, refBuf, bandgap, flagN, irq;
  logic [1:0]  bresp, rsp;
  logic [31:0] rdata, rdv;
  logic [11:0] code;
  logic [2:0]  chan;
  int          fails = 0;
  int          num_checks = 0;

  always #25 clk = ~clk;

  conv_source #(.CODE(CODE)) i_src (.run(resetn), .extClk(extClk), .code(code));

  // ready lines held high: the answer is always taken at once
  adc_clock_and_powerdown_control i_dut (
    .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rsp), .rvalid(rvalid), .rready(1'b1),
    .extClkIn(extClk), .analogCode(code), .shutdown_pin_n(shdnN), .channelSel(chan),
    .rangeSel(rangeSel), .refBufferEnable(refBuf), .bandgapEnable(bandgap),
    .conversionDoneFlagN(flagN), .irq(irq)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tmo();
    fails++;
    $display("MISMATCH wait expected answer seen timeout");
    print_verdict();
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit b;
    b = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 100 && !b; n++) begin
      @(posedge clk);
      // release only a still-raised valid so a following call never doubles a drive
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      b = bvalid;
    end
    if (!b) tmo();
  endtask

  task automatic rd(input logic [7:0] a);
    bit b;
    b = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 100 && !b; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      b = rvalid;
      rdv = rdata;
    end
    if (!b) tmo();
  endtask

  task automatic cr(input logic [7:0] a, input logic [31:0] e, input string s);
    rd(a);
    chk(s, e, rdv);
  endtask

  task automatic waitDone(input int lo, input int hi);
    int n;
    for (n = 0; n < 1000 && flagN !== 1'b0; n++) @(posedge clk);
    if (n == 1000) tmo();
    chk("conversion cycles", 32'h1, 32'(n >= lo && n <= hi));
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("flag", 32'h1, 32'(flagN));
    chk("buffer", 32'h1, 32'(refBuf));
    cr(STATUS_OFS, 32'h10, "status");
    cr(IRQ_ENABLE_OFS, 32'h0, "irq enable");
    cr(8'h20, 32'h0, "unmapped data");
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rsp));
    wr(8'h20, 32'h1);
    chk("unmapped wresp", 32'(RESP_SLVERR), 32'(bresp));
    wr(IRQ_ENABLE_OFS, 32'h1);
    chk("wresp", 32'(RESP_OKAY), 32'(bresp));
  endtask

  task automatic t_ext();
    wr(CTRL_OFS, 32'h01);
    waitDone(320, 400);
    chk("channel", 32'h1, 32'(chan));
    cr(STATUS_OFS, 32'h0, "status ext");
    chk("irq", 32'h1, 32'(irq));
    cr(RESULT_OFS, {20'h0, CODE}, "unipolar");
    tick(1);
    chk("flag read", 32'h1, 32'(flagN));
    wr(IRQ_CLEAR_OFS, 32'h7);
    tick(2);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask

  task automatic t_intBipolar();
    logic [11:0] b;
    b = {~CODE[11], CODE[10:0]};
    wr(IRQ_ENABLE_OFS, 32'h0);
    wr(CTRL_OFS, 32'h48);
    waitDone(220, 250);
    tick(2);
    chk("irq masked", 32'h0, 32'(irq));
    cr(IRQ_STATUS_OFS, 32'h1, "irq status");
    wr(IRQ_ENABLE_OFS, 32'h1);
    tick(2);
    chk("irq enabled", 32'h1, 32'(irq));
    cr(STATUS_OFS, 32'h02, "status int");
    wr(CTRL_OFS, 32'h00);
    chk("flag write", 32'h1, 32'(flagN));
    cr(RESULT_OFS, {16'h0, {4{b[11]}}, b}, "bipolar");
    wr(CTRL_OFS, 32'h40);
    waitDone(0, 250);
    wr(IRQ_CLEAR_OFS, 32'h1);
    cr(RESULT_OFS, {20'h0, CODE}, "result");
  endtask

  task automatic t_standby();
    wr(CTRL_OFS, 32'h80);
    cr(STATUS_OFS, 32'h13, "standby waits");
    waitDone(0, 250);
    tick(2);
    cr(STATUS_OFS, 32'h06, "standby");
    chk("buffer standby", 32'h1, 32'(refBuf));
    cr(RESULT_OFS, {20'h0, CODE}, "result standby");
  endtask

  task automatic t_deep();
    wr(CTRL_OFS, 32'hc0);
    cr(STATUS_OFS, 32'h13, "deep waits");
    waitDone(0, 250);
    tick(2);
    cr(STATUS_OFS, 32'h0a, "deep");
    chk("buffer deep", 32'h0, 32'(refBuf));
    cr(RESULT_OFS, {20'h0, CODE}, "result deep");
    wr(CTRL_OFS, 32'h00);
    rd(STATUS_OFS);
    chk("deep left", 32'h0, 32'(rdv[ST_DEEP]));
    chk("clock ext", 32'h0, 32'(rdv[ST_CLK_INT]));
    chk("buffer back", 32'h1, 32'(refBuf));
    waitDone(0, 400);
    rd(RESULT_OFS);
  endtask

  task automatic t_shutdown_pin_n();
    wr(IRQ_CLEAR_OFS, 32'h7);
    wr(CTRL_OFS, 32'h40);
    tick(20);
    shdnN <= 1'b0;
    tick(3);
    chk("buffer shutdown_pin_n", 32'h0, 32'(refBuf));
    cr(STATUS_OFS, 32'h3a, "shutdown");
    rd(IRQ_STATUS_OFS);
    chk("abort", 32'h1, 32'(rdv[IRQ_ABORT]));
    tick(400);
    chk("no result", 32'h1, 32'(flagN));
    shdnN <= 1'b1;
    tick(3);
    cr(STATUS_OFS, 32'h12, "released");
    // external acquisition: second write converts at once, twelve clocks only
    wr(CTRL_OFS, 32'h70);
    chk("range", 32'h1, 32'(rangeSel));
    cr(STATUS_OFS, 32'h13, "ext acquisition");
    wr(CTRL_OFS, 32'h40);
    waitDone(140, 170);
    cr(RESULT_OFS, {20'h0, CODE}, "result ext acq");
  endtask

  initial begin
    tick(12);
    resetn <= 1'b1;
    tick(1);
    t_reset();
    t_ext();
    t_intBipolar();
    t_standby();
    t_deep();
    t_shutdown_pin_n();
    print_verdict();
  end
endmodule
`default_nettype wire
